// ===== rtl/ycsr_regs.v
// Serially accessed control and status registers of the Y/C separator
`timescale 1ns/10ps
`default_nettype none
`include "ycsr_map.vh"

// Summary of operation
// [RL1] Answer read address B9h with select pin low, BBh with select pin high.
// [RL2] Mode bit: zero 3D/2D separation, one 2D plus noise reduction; both burst-locked.
// [RL3] Chroma field: 00 gain2 raw, 01 gain2 BPF, 10 gain1 raw, 11 gain1 BPF.
// [RL4] Luma correction: 00 off, 01 analog, 10 digital, 11 both; resets 11.
// [RL5] Clock force: 00 follows mode, 01 burst-locked, 1x line-locked; resets 00.
// [RL6] Standard force: 00 follows detection, 01 standard, 10 horizontal nonstandard.
// [RL7] Standard force 11 means vertical nonstandard processing, forcing inter-line.
// [RL8] Frame/line: 00 adaptive from line pin and motion, 01 frame, 1x line; code gives frame on 01 only while the line pin is high.
// [RL9] Killer: 00 pin or internal detect, 01 pin only, 1x forced; resets 01.
// [RL10] During killer processing chroma is not subtracted from composite for luma.
// [RL11] Host must pick forced clock and standard codes that fit the input.
// [RL12] Reads take no subaddress, start at register 0, run until master NACK.
// [RL13] Writes take subaddress in second byte, then auto-increment per data byte.
// [RL14] Reset loads initial values; interface is operative 100 us after reset.
// [RL15] Read registers are status only; writes go to separate write space.
module ycsr_regs #(
  parameter READY_CYCLES = `YCSR_READY_TIME_US * `YCSR_CLK_MHZ
) (
  input  wire       clk,
  input  wire       rst_n,
  input  wire       scl_in,
  input  wire       sda_in,
  output wire       sda_out,
  output wire       sda_oe,
  input  wire       address_select_pin,
  input  wire       killer_input_pin,
  input  wire       line_pin_input,
  input  wire       motion_detect,
  input  wire       killer_detect_flag,
  input  wire       nonstandard_detect_flag,
  input  wire [7:0] detection_status_flags,
  input  wire [7:0] wide_signal_line_status,
  input  wire [7:0] extended_id_bits_low,
  input  wire [7:0] extended_id_bits_high,
  input  wire [7:0] id_word_zero_one,
  input  wire [7:0] id_word_two,
  input  wire [7:0] decoder_check_flags,
  output reg        operating_mode_bit,
  output reg        chroma_gain_two,
  output reg        chroma_bpf_en,
  output reg        luma_corr_analog,
  output reg        luma_corr_digital,
  output reg        line_locked_clock,
  output reg        nonstd_hsync_proc,
  output reg        nonstd_vsync_proc,
  output reg        interframe_proc,
  output reg        killer_active,
  output reg        chroma_subtract_en
);

  // ===================================================================
  // Bus state machine codes
  localparam [2:0] ST_IDLE = 3'd0;
  localparam [2:0] ST_RX   = 3'd1;
  localparam [2:0] ST_ACK  = 3'd2;
  localparam [2:0] ST_TX   = 3'd3;
  localparam [2:0] ST_TACK = 3'd4;
  localparam [1:0] PH_ADDR = 2'd0;
  localparam [1:0] PH_SUB  = 2'd1;
  localparam [1:0] PH_DATA = 2'd2;

  // ===================================================================
  // Pin synchronisers: three stages, accept when stages two and three agree
  reg  [4:0] s1_q;
  reg  [4:0] s2_q;
  reg  [4:0] s3_q;
  reg  [4:0] filt_q;
  reg  [4:0] filt_p_q;
  wire [4:0] pins = {line_pin_input, killer_input_pin, address_select_pin, sda_in, scl_in};
  // Bus lines idle high, side pins low: no false edge or killer pulse after reset
  localparam [4:0] SYNC_IDLE = 5'h03;
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi = gi + 1) begin : g_sync
      always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          s1_q[gi]     <= SYNC_IDLE[gi];
          s2_q[gi]     <= SYNC_IDLE[gi];
          s3_q[gi]     <= SYNC_IDLE[gi];
          filt_q[gi]   <= SYNC_IDLE[gi];
          filt_p_q[gi] <= SYNC_IDLE[gi];
        end else begin
          s1_q[gi]     <= pins[gi];
          s2_q[gi]     <= s1_q[gi];
          s3_q[gi]     <= s2_q[gi];
          filt_q[gi]   <= (s2_q[gi] == s3_q[gi]) ? s3_q[gi] : filt_q[gi];
          filt_p_q[gi] <= filt_q[gi];
        end
      end
    end
  endgenerate

  wire scl_f    = filt_q[0];
  wire sda_f    = filt_q[1];
  wire sel_f    = filt_q[2];
  wire kil_f    = filt_q[3];
  wire line_f   = filt_q[4];
  wire scl_rise = scl_f & ~filt_p_q[0];
  wire scl_fall = ~scl_f & filt_p_q[0];
  wire start_c  = scl_f & filt_p_q[0] & filt_p_q[1] & ~sda_f;
  wire stop_c   = scl_f & filt_p_q[0] & ~filt_p_q[1] & sda_f;

  // ===================================================================
  // Ready timer; the bus is ignored until it expires
  reg [31:0] ready_cnt_q;
  reg        ready_q;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ready_cnt_q <= 32'h0000_0000;
      ready_q     <= 1'b0;
    end else if (!ready_q) begin
      ready_cnt_q <= ready_cnt_q + 32'h0000_0001;
      ready_q     <= (ready_cnt_q >= READY_CYCLES - 1); // [RL14]
    end
  end

  // ===================================================================
  // Read mux: status inputs only, nothing here is writable
  reg [7:0] ptr_q;
  reg [7:0] rd_data;
  always @* begin
    case (ptr_q) // [RL15]
      `YCSR_DETECTION_STATUS_FLAGS:  rd_data = detection_status_flags;
      `YCSR_WIDE_SIGNAL_LINE_STATUS: rd_data = wide_signal_line_status;
      `YCSR_EXTENDED_ID_BITS_LOW:    rd_data = extended_id_bits_low;
      `YCSR_EXTENDED_ID_BITS_HIGH:   rd_data = extended_id_bits_high;
      `YCSR_ID_WORD_ZERO_ONE:        rd_data = id_word_zero_one;
      `YCSR_ID_WORD_TWO:             rd_data = id_word_two;
      `YCSR_DECODER_CHECK_FLAGS:     rd_data = decoder_check_flags;
      default:                       rd_data = 8'h00;
    endcase
  end

  // ===================================================================
  // Serial slave
  reg [2:0] state_q;
  reg [1:0] phase_q;
  reg [3:0] bitcnt_q;
  reg [7:0] shreg_q;
  reg       rw_q;
  reg       oe_q;
  reg [7:0] cfg0_q;
  reg [7:0] cfg1_q;
  wire [7:0] wr_addr = sel_f ? `YCSR_SLV_WR_HI : `YCSR_SLV_WR_LO;
  wire [7:0] rd_addr = sel_f ? `YCSR_SLV_RD_HI : `YCSR_SLV_RD_LO;
  assign sda_out = 1'b0;
  assign sda_oe  = oe_q;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q  <= ST_IDLE;
      phase_q  <= PH_ADDR;
      bitcnt_q <= 4'h0;
      shreg_q  <= 8'h00;
      rw_q     <= 1'b0;
      oe_q     <= 1'b0;
      ptr_q    <= 8'h00;
      cfg0_q   <= `YCSR_CFG0_RESET; // [RL14]
      cfg1_q   <= `YCSR_CFG1_RESET;
    end else if (!ready_q) begin
      state_q <= ST_IDLE;
      oe_q    <= 1'b0;
    end else if (start_c) begin
      state_q  <= ST_RX;
      phase_q  <= PH_ADDR;
      bitcnt_q <= 4'h0;
      oe_q     <= 1'b0;
    end else if (stop_c) begin
      state_q <= ST_IDLE;
      oe_q    <= 1'b0;
    end else begin
      case (state_q)
        ST_RX: begin
          if (scl_rise && bitcnt_q != 4'h8) begin
            shreg_q  <= {shreg_q[6:0], sda_f};
            bitcnt_q <= bitcnt_q + 4'h1;
          end else if (scl_fall && bitcnt_q == 4'h8) begin
            state_q <= ST_ACK;
            oe_q    <= 1'b1;
            case (phase_q)
              PH_ADDR: begin
                if (shreg_q == wr_addr) begin
                  rw_q    <= 1'b0;
                  phase_q <= PH_SUB;
                end else if (shreg_q == rd_addr) begin // [RL1]
                  rw_q    <= 1'b1;
                  phase_q <= PH_DATA;
                  ptr_q   <= 8'h00; // [RL12]
                end else begin
                  state_q <= ST_IDLE;
                  oe_q    <= 1'b0;
                end
              end
              PH_SUB: begin
                ptr_q   <= shreg_q; // [RL13]
                phase_q <= PH_DATA;
              end
              default: begin
                if (ptr_q == `YCSR_MODE_AND_OUTPUT_CONFIG) cfg0_q <= shreg_q;
                if (ptr_q == `YCSR_FORCED_PROCESSING_SELECT) cfg1_q <= shreg_q;
                ptr_q <= ptr_q + 8'h01; // [RL13]
              end
            endcase
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            if (rw_q) begin
              state_q  <= ST_TX;
              shreg_q  <= rd_data;
              oe_q     <= ~rd_data[7];
              bitcnt_q <= 4'h1;
            end else begin
              state_q  <= ST_RX;
              oe_q     <= 1'b0;
              bitcnt_q <= 4'h0;
            end
          end
        end
        ST_TX: begin
          if (scl_fall) begin
            if (bitcnt_q == 4'h8) begin
              state_q <= ST_TACK;
              oe_q    <= 1'b0;
            end else begin
              shreg_q  <= {shreg_q[6:0], 1'b0};
              oe_q     <= ~shreg_q[6];
              bitcnt_q <= bitcnt_q + 4'h1;
            end
          end
        end
        ST_TACK: begin
          if (scl_rise) begin
            if (sda_f) begin
              state_q <= ST_IDLE; // [RL12]
            end else begin
              state_q <= ST_ACK;
              ptr_q   <= ptr_q + 8'h01;
            end
          end
        end
        default: oe_q <= 1'b0;
      endcase
    end
  end

  // ===================================================================
  // Control decode; outputs registered so they never glitch mid-write
  wire [1:0] clk_sel = cfg1_q[`YCSR_CLOCK_FORCE_MSB:`YCSR_CLOCK_FORCE_LSB];
  wire [1:0] std_sel = cfg1_q[`YCSR_STD_FORCE_MSB:`YCSR_STD_FORCE_LSB];
  wire [1:0] fl_sel  = cfg1_q[`YCSR_FRAME_LINE_MSB:`YCSR_FRAME_LINE_LSB];
  wire [1:0] kil_sel = cfg1_q[`YCSR_KILLER_FORCE_MSB:`YCSR_KILLER_FORCE_LSB];
  wire       kil_d   = kil_sel[1] | kil_f | (kil_sel == 2'b00 && killer_detect_flag); // [RL9]
  wire       vns_d   = (std_sel == 2'b11); // [RL7]
  reg        ifr_d;
  always @* begin
    case (fl_sel) // [RL8]
      2'b00:   ifr_d = line_f & ~motion_detect;
      2'b01:   ifr_d = line_f;
      default: ifr_d = 1'b0;
    endcase
  end
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      operating_mode_bit <= 1'b0;
      chroma_gain_two    <= 1'b0;
      chroma_bpf_en      <= 1'b1;
      luma_corr_analog   <= 1'b1;
      luma_corr_digital  <= 1'b1;
      line_locked_clock  <= 1'b0;
      nonstd_hsync_proc  <= 1'b0;
      nonstd_vsync_proc  <= 1'b0;
      interframe_proc    <= 1'b0;
      killer_active      <= 1'b0;
      chroma_subtract_en <= 1'b1;
    end else begin
      operating_mode_bit <= cfg0_q[`YCSR_OPERATING_MODE_BIT]; // [RL2]
      chroma_gain_two    <= ~cfg0_q[`YCSR_CHROMA_OUT_GAIN_BIT]; // [RL3]
      chroma_bpf_en      <= cfg0_q[`YCSR_CHROMA_OUT_BPF_BIT]; // [RL3]
      luma_corr_analog   <= cfg0_q[`YCSR_LUMA_CORR_ANA_BIT]; // [RL4]
      luma_corr_digital  <= cfg0_q[`YCSR_LUMA_CORR_DIG_BIT]; // [RL4]
      // Both modes are burst-locked, so only a 1x code selects line lock
      line_locked_clock  <= clk_sel[1]; // [RL5]
      nonstd_hsync_proc  <= (std_sel == 2'b10) ||
                            (std_sel == 2'b00 && nonstandard_detect_flag); // [RL6]
      nonstd_vsync_proc  <= vns_d; // [RL7]
      interframe_proc    <= ifr_d & ~vns_d; // [RL7]
      killer_active      <= kil_d; // [RL9]
      chroma_subtract_en <= ~kil_d; // [RL10]
    end
  end

endmodule // ycsr_regs
`default_nettype wire

// ===== rtl/ycsr_map.vh
// Register offsets, field positions, reset values and timing for the Y/C control registers
`ifndef YCSR_MAP_VH
`define YCSR_MAP_VH

// =====================================================================
// Serial slave addresses (write / read, per address-select level)
`define YCSR_SLV_WR_LO      8'hB8
`define YCSR_SLV_RD_LO      8'hB9
`define YCSR_SLV_WR_HI      8'hBA
`define YCSR_SLV_RD_HI      8'hBB

// =====================================================================
// Register offsets
`define YCSR_MODE_AND_OUTPUT_CONFIG   8'h00
`define YCSR_FORCED_PROCESSING_SELECT 8'h01
`define YCSR_DETECTION_STATUS_FLAGS   8'h00
`define YCSR_WIDE_SIGNAL_LINE_STATUS  8'h01
`define YCSR_EXTENDED_ID_BITS_LOW     8'h02
`define YCSR_EXTENDED_ID_BITS_HIGH    8'h03
`define YCSR_ID_WORD_ZERO_ONE         8'h04
`define YCSR_ID_WORD_TWO              8'h05
`define YCSR_DECODER_CHECK_FLAGS      8'h06

// =====================================================================
// Field positions
`define YCSR_OPERATING_MODE_BIT       6
`define YCSR_CHROMA_OUT_GAIN_BIT      3
`define YCSR_CHROMA_OUT_BPF_BIT       2
`define YCSR_LUMA_CORR_DIG_BIT        1
`define YCSR_LUMA_CORR_ANA_BIT        0
`define YCSR_CLOCK_FORCE_MSB          7
`define YCSR_CLOCK_FORCE_LSB          6
`define YCSR_STD_FORCE_MSB            5
`define YCSR_STD_FORCE_LSB            4
`define YCSR_FRAME_LINE_MSB           3
`define YCSR_FRAME_LINE_LSB           2
`define YCSR_KILLER_FORCE_MSB         1
`define YCSR_KILLER_FORCE_LSB         0

// =====================================================================
// Reset values (undefined bits as initial values: D7=0, D5-D4=01)
`define YCSR_CFG0_RESET     8'h1F
`define YCSR_CFG1_RESET     8'h01

// =====================================================================
// Timing: interface ready time after reset
`define YCSR_READY_TIME_US  100
`define YCSR_CLK_MHZ        100
`endif

// ===== sim/ycsr_i2c_master.sv
// Behavioural serial bus master for the Y/C control registers
`timescale 1ns/10ps
`default_nettype none
module ycsr_i2c_master (
  input  wire logic clk,
  input  wire logic sda,
  output var  logic scl,
  output var  logic sda_pull
);
  // ========
  // Bus timing
  // 120 clocks a phase keeps SCL at 400 kHz
  localparam int HALF = 120;
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // ========
  // Framing
  task automatic start();
    sda_pull = 1'b0;
    tick(10);
    scl = 1'b1;
    tick(HALF);
    sda_pull = 1'b1;
    tick(HALF);
    scl = 1'b0;
    tick(10);
  endtask
  // Master has already released SDA on a read, so the STOP is clean
  task automatic stop();
    sda_pull = 1'b1;
    tick(HALF);
    scl = 1'b1;
    tick(HALF);
    sda_pull = 1'b0;
    tick(HALF);
  endtask
  // Nine bits out, nine bits sampled; a 1 releases the line to the pull-up
  task automatic byte_io(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) begin
      sda_pull = !tx[i];
      tick(HALF);
      scl = 1'b1;
      tick(HALF);
      rx[i] = sda;
      scl = 1'b0;
      // Hold SDA past the fall; both pins pass equal sync stages
      tick(10);
    end
  endtask
endmodule // ycsr_i2c_master
`default_nettype wire

// ===== sim/ycsr_regs_properties.sv
// Port-level assertions for the Y/C control register block
`timescale 1ns/10ps
`default_nettype none
module ycsr_regs_props #(
  parameter READY_CYCLES = 10000
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic scl_in,
  input wire logic sda_oe,
  input wire logic killer_input_pin,
  input wire logic line_pin_input,
  input wire logic operating_mode_bit,
  input wire logic chroma_gain_two,
  input wire logic chroma_bpf_en,
  input wire logic luma_corr_analog,
  input wire logic luma_corr_digital,
  input wire logic line_locked_clock,
  input wire logic nonstd_hsync_proc,
  input wire logic nonstd_vsync_proc,
  input wire logic interframe_proc,
  input wire logic killer_active,
  input wire logic chroma_subtract_en
);
  // ========
  // Saturating count since reset release
  logic [15:0] cnt_q;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) cnt_q <= 16'h0000;
    else if (cnt_q != 16'hFFFF) cnt_q <= cnt_q + 16'h0001;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_ready; (cnt_q < READY_CYCLES) |-> !sda_oe; endproperty
  a_ready: assert property (p_ready) else $error("SDA driven before ready");
  property p_reset;
    $rose(rst_n) |-> !operating_mode_bit && !chroma_gain_two && chroma_bpf_en &&
      luma_corr_analog && luma_corr_digital && !line_locked_clock && !nonstd_vsync_proc;
  endproperty
  a_reset: assert property (p_reset) else $error("bad reset decode");
  property p_sub; chroma_subtract_en != killer_active; endproperty
  a_sub: assert property (p_sub) else $error("subtract not inverse of killer");
  property p_kpin; killer_input_pin [*6] |-> killer_active; endproperty
  a_kpin: assert property (p_kpin) else $error("killer pin ignored");
  // Line pin passes the three-stage filter, so allow its latency
  property p_line; !line_pin_input [*6] |-> !interframe_proc; endproperty
  a_line: assert property (p_line) else $error("frame mode without line pin");
  property p_vline; nonstd_vsync_proc |-> !interframe_proc; endproperty
  a_vline: assert property (p_vline) else $error("vertical mode not inter-line");
  property p_vh; nonstd_vsync_proc |-> !nonstd_hsync_proc; endproperty
  a_vh: assert property (p_vh) else $error("both sync modes active");
  // Slave may only move SDA while SCL is low, or it fakes START/STOP
  property p_sda; $changed(sda_oe) |-> !scl_in; endproperty
  a_sda: assert property (p_sda) else $error("SDA moved with SCL high");
  c_ack: cover property (sda_oe && scl_in);
  c_vs: cover property (nonstd_vsync_proc);
  c_kf: cover property (killer_active && !killer_input_pin);
endmodule // ycsr_regs_props
bind ycsr_regs ycsr_regs_props #(.READY_CYCLES(READY_CYCLES)) props_u (
  .clk, .rst_n, .scl_in, .sda_oe, .killer_input_pin, .line_pin_input, .operating_mode_bit,
  .chroma_gain_two, .chroma_bpf_en, .luma_corr_analog, .luma_corr_digital, .line_locked_clock,
  .nonstd_hsync_proc, .nonstd_vsync_proc, .interframe_proc, .killer_active, .chroma_subtract_en
);
`default_nettype wire

// ===== sim/ycsr_regs_tb.sv
// Self-checking bench for the Y/C control register block
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, exp, got) begin checked++; if ((got) !== (exp)) begin err_count++; \
  $display("ERROR %s expected %h seen %h", nm, exp, got); end end
module ycsr_regs_tb;
  // Short ready time; the first access still falls inside it
  localparam int READY = 400;
  logic       clk, rst_n, sel, kpin, line, motion, kflag, nflag;
  logic [7:0] st [0:6];
  logic [7:0] c0, c1;
  wire        scl, sda_pull, sda_oe, sda_out, sda;
  wire [10:0] o;
  int         err_count = 0;
  int         checked = 0;
  int         cyc = 0;
  assign sda = !((sda_oe && !sda_out) || sda_pull);
  ycsr_i2c_master mst_u (.clk(clk), .sda(sda), .scl(scl), .sda_pull(sda_pull));
  ycsr_regs #(.READY_CYCLES(READY)) dut_u (
    .clk(clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .address_select_pin(sel), .killer_input_pin(kpin), .line_pin_input(line),
    .motion_detect(motion), .killer_detect_flag(kflag), .nonstandard_detect_flag(nflag),
    .detection_status_flags(st[0]), .wide_signal_line_status(st[1]),
    .extended_id_bits_low(st[2]), .extended_id_bits_high(st[3]), .id_word_zero_one(st[4]),
    .id_word_two(st[5]), .decoder_check_flags(st[6]), .operating_mode_bit(o[10]),
    .chroma_gain_two(o[9]), .chroma_bpf_en(o[8]), .luma_corr_analog(o[7]),
    .luma_corr_digital(o[6]), .line_locked_clock(o[5]), .nonstd_hsync_proc(o[4]),
    .nonstd_vsync_proc(o[3]), .interframe_proc(o[2]), .killer_active(o[1]),
    .chroma_subtract_en(o[0]));
  // ========
  // Expected decode of both config bytes with the current side inputs
  function automatic logic [10:0] exp_dec(input logic [7:0] a, input logic [7:0] b);
    logic k;
    k = b[1] | kpin | (!b[0] & kflag);
    return {a[6], !a[3], a[2], a[0], a[1], b[7], b[5:4] == 2'b10 || (b[5:4] == 2'b00 && nflag),
            b[5:4] == 2'b11, b[5:4] != 2'b11 && !b[3] && line && (b[2] || !motion), k, !k};
  endfunction
  task automatic wr(input logic [7:0] sub, d0, d1, input logic ok);
    logic [8:0]  r;
    logic [31:0] f;
    f = {sel ? 8'hBA : 8'hB8, sub, d0, d1};
    mst_u.start();
    for (int i = 3; i >= 0; i--) begin
      mst_u.byte_io({f[i*8 +: 8], 1'b1}, r);
      `CHK("write ack", !ok, r[0])
    end
    mst_u.stop();
  endtask
  task automatic rd(input logic [7:0] a, input int n, input logic ok);
    logic [8:0] r;
    mst_u.start();
    mst_u.byte_io({a, 1'b1}, r);
    `CHK("read ack", !ok, r[0])
    for (int k = 0; k < n; k++) begin
      mst_u.byte_io({8'hFF, k == n - 1}, r);
      `CHK("read data", k < 7 ? st[k] : 8'h00, r[8:1])
    end
    mst_u.stop();
  endtask
  task automatic stop_test();
    $display("checked %0d err_count %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 90000) begin
      err_count++;
      stop_test();
    end
  end
  initial begin
    rst_n = 1'b0;
    {sel, kpin, line, motion, kflag, nflag} = 6'h00;
    for (int k = 0; k < 7; k++) st[k] = 8'h5A ^ 8'(k * 41);
    repeat (3) @(posedge clk);
    #1 rst_n = 1'b1;
    wr(8'h00, 8'h40, 8'hC2, 1'b0);
    `CHK("reset", exp_dec(8'h1F, 8'h01), o)
    rd(8'hBB, 0, 1'b0);
    rd(8'hB9, 1, 1'b1);
    // Select pin is fixed while powered, so change it under reset
    sel = 1'b1;
    rst_n = 1'b0;
    mst_u.tick(2);
    rst_n = 1'b1;
    mst_u.tick(READY);
    rd(8'hB9, 0, 1'b0);
    for (int i = 0; i < 4; i++) begin
      c0 = {1'b0, i[0], 2'b01, 2'(i), 2'(i)};
      c1 = {4{2'(i)}};
      {nflag, motion, kflag, line} = {!i[1], i[0], 2'b11};
      wr(8'h00, c0, c1, 1'b1);
      `CHK("decode", exp_dec(c0, c1), o)
      kpin = 1'b1;
      mst_u.tick(8);
      `CHK("killer pin", 1'b1, o[1])
      kpin = 1'b0;
    end
    rd(8'hBB, 8, 1'b1);
    stop_test();
  end
endmodule // ycsr_regs_tb
`default_nettype wire
